// *** common/ssp_pkg.sv ***
// Purpose: shared constants and types of the synchronous serial port
// Assumes: 32-bit register bus with byte addresses in the low 12 bits
// Notes:   every register takes one aligned word; upper bits read zero
package ssp_pkg;

   // register byte offsets
   localparam logic [11:0] SSP_OFS_CONTROL_ZERO   = 12'h000;
   localparam logic [11:0] SSP_OFS_CONTROL_ONE    = 12'h004;
   localparam logic [11:0] SSP_OFS_FIFO_DATA      = 12'h008;
   localparam logic [11:0] SSP_OFS_FIFO_STATUS    = 12'h00c;
   localparam logic [11:0] SSP_OFS_CLOCK_PRESCALE = 12'h010;
   localparam logic [11:0] SSP_OFS_INTERRUPT_ID   = 12'h014;

   // values after reset
   localparam logic [15:0] SSP_RST_CONTROL_ZERO   = 16'h0000;
   localparam logic [6:0]  SSP_RST_CONTROL_ONE    = 7'h00;
   localparam logic [7:0]  SSP_RST_CLOCK_PRESCALE = 8'h00;
   localparam logic [4:0]  SSP_RST_FIFO_STATUS    = 5'h03;

   // control_zero field positions
   localparam int SSP_CR0_SIZE_LSB = 0;
   localparam int SSP_CR0_SIZE_MSB = 3;
   localparam int SSP_CR0_FMT_LSB  = 4;
   localparam int SSP_CR0_FMT_MSB  = 5;
   localparam int SSP_CR0_POL      = 6;
   localparam int SSP_CR0_PHA      = 7;
   localparam int SSP_CR0_RATE_LSB = 8;
   localparam int SSP_CR0_RATE_MSB = 15;

   // control_one field positions
   localparam int SSP_CR1_RX_IE  = 0;
   localparam int SSP_CR1_TX_IE  = 1;
   localparam int SSP_CR1_ROR_IE = 2;
   localparam int SSP_CR1_LOOP   = 3;
   localparam int SSP_CR1_ENABLE = 4;
   localparam int SSP_CR1_SLAVE  = 5;
   localparam int SSP_CR1_SOD    = 6;

   // frame formats
   localparam logic [1:0] SSP_FMT_SPI   = 2'h0;
   localparam logic [1:0] SSP_FMT_PULSE = 2'h1;
   localparam logic [1:0] SSP_FMT_CMD   = 2'h2;

   // data path sizes and counts
   localparam int          SSP_WORD_W     = 16;
   localparam int          SSP_FIFO_DEPTH = 8;
   localparam logic [3:0]  SSP_FIFO_HALF  = 4'h4;
   localparam logic [4:0]  SSP_CMD_BITS   = 5'h08;
   localparam logic [4:0]  SSP_WORD_BITS  = 5'h10;

   typedef enum logic [2:0] {
      SSP_IDLE,
      SSP_PULSE,
      SSP_SHIFT,
      SSP_TURN,
      SSP_RECV,
      SSP_GAP
   } ssp_state_t;

endpackage : ssp_pkg

// *** rtl/ssp_fifo.sv ***
// Purpose: first-in first-out store between bus side and serial engine
// Assumes: DEPTH is a power of two
// Notes:   head word is read straight from the storage flip-flops
module ssp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH):0]          count
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } ssp_fifo_st_t;

   ssp_fifo_st_t st_ff;
   ssp_fifo_st_t nxt_st;
   logic         do_push;
   logic         do_pop;

   assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_ff.cnt != '0);
   assign out_data  = st_ff.mem[st_ff.rp];
   assign count     = st_ff.cnt;
   assign do_push   = in_valid & in_ready;
   assign do_pop    = out_valid & out_ready;

   always_comb
   begin
      nxt_st = st_ff;
      if (do_push)
      begin
         nxt_st.mem[st_ff.wp] = in_data;
         nxt_st.wp            = st_ff.wp + AW'(1);
      end
      if (do_pop)
         nxt_st.rp = st_ff.rp + AW'(1);
      // simultaneous push and pop keeps the fill level
      if (do_push && !do_pop)
         nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
      else if (do_pop && !do_push)
         nxt_st.cnt = st_ff.cnt - (AW+1)'(1);
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   AST_FIFO_BOUND: assert property (@(posedge clock) disable iff (rst)
      st_ff.cnt <= (AW+1)'(DEPTH))
      else $error("fifo fill level beyond depth");

endmodule : ssp_fifo

// *** rtl/ssp_port.sv ***
// Purpose: synchronous serial port, master or slave, three frame formats
// Assumes: pins and bus inputs are synchronous to clock
// Notes:   data register writes stall the bus while the send fifo is full
//
// Overview of operation
// - size field plus one gives word length, 1 to 16 bits
// - format 00 clock phase/polarity, 01 frame pulse, 10 command/response
// - clock polarity and phase only matter in the first format
// - rate field in control_zero upper byte sets bit rate with prescale
// - receive service interrupt when enabled and receive fifo half full
// - transmit service interrupt when enabled and send fifo half empty
// - overrun enable gates overrun interrupt; writing zero clears it
// - loopback feeds transmit shifter output into receive shifter
// - no serial transfers while the port enable bit is zero
// - slave with output disable never drives the transmit line
// - status bits 0,1 show send fifo empty and not full, reset 1
// - status bits 2,3 show receive fifo not empty and full, reset 0
// - identification register shows two service and the overrun status
// - undefined register bits read as zero
module ssp_port (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        serial_clock_in,
   output logic             serial_clock_out,
   output logic             serial_clock_oe_n,
   input  wire logic        frame_in,
   output logic             frame_out,
   output logic             frame_oe_n,
   input  wire logic        serial_rx_line,
   output logic             serial_tx_line,
   output logic             serial_tx_oe_n,
   output logic             rx_service_irq,
   output logic             tx_service_irq,
   output logic             rx_overrun_irq
);
   typedef struct packed {
      ssp_pkg::ssp_state_t state;
      logic                phase;
      logic [15:0]         tmr;
      logic [4:0]          cnt;
      logic [15:0]         tx_sh;
      logic [15:0]         rx_sh;
      logic                sclk_q;
      logic                ror;
      logic [15:0]         cr0;
      logic [6:0]          cr1;
      logic [7:0]          cpsr;
      logic [31:0]         rdata;
      logic                err;
   } ssp_port_st_t;

   ssp_port_st_t st_ff;
   ssp_port_st_t nxt_st;

   logic        tx_valid;
   logic        tx_pop;
   logic [15:0] tx_word;
   logic [3:0]  tx_count;
   logic        tx_in_ready;
   logic        tx_push;
   logic        rx_valid;
   logic        rx_pop;
   logic [15:0] rx_word;
   logic [3:0]  rx_count;
   logic        rx_in_ready;
   logic        rx_push;
   logic [15:0] rx_data;

   logic        enable;
   logic        slave;
   logic        slave_output_disable;
   logic        loop;
   logic [1:0]  fmt;
   logic        pol;
   logic        pha;
   logic        cmd_m;
   logic [4:0]  nbits;
   logic [4:0]  limit;
   logic [15:0] mask;
   logic [15:0] half_len;
   logic [6:0]  pre_half;
   logic        samp_lvl;
   logic        ev_a;
   logic        ev_b;
   logic        rx_bit;
   logic        last;
   logic        start;
   logic        in_frame;
   logic        idle_clk;
   logic        acc;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic        ror_set;
   logic        ror_clr;

   ssp_fifo #(.WIDTH(ssp_pkg::SSP_WORD_W), .DEPTH(ssp_pkg::SSP_FIFO_DEPTH))
   u_tx_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (tx_push),
      .in_ready  (tx_in_ready),
      .in_data   (pwdata[15:0]),
      .out_valid (tx_valid),
      .out_ready (tx_pop),
      .out_data  (tx_word),
      .count     (tx_count)
   );

   ssp_fifo #(.WIDTH(ssp_pkg::SSP_WORD_W), .DEPTH(ssp_pkg::SSP_FIFO_DEPTH))
   u_rx_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (rx_push),
      .in_ready  (rx_in_ready),
      .in_data   (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_pop),
      .out_data  (rx_word),
      .count     (rx_count)
   );

   // configuration decode
   assign enable   = st_ff.cr1[ssp_pkg::SSP_CR1_ENABLE];
   assign slave    = st_ff.cr1[ssp_pkg::SSP_CR1_SLAVE];
   assign slave_output_disable      = st_ff.cr1[ssp_pkg::SSP_CR1_SOD];
   assign loop     = st_ff.cr1[ssp_pkg::SSP_CR1_LOOP];
   assign fmt      = st_ff.cr0[ssp_pkg::SSP_CR0_FMT_MSB:
                               ssp_pkg::SSP_CR0_FMT_LSB];
   assign pol      = st_ff.cr0[ssp_pkg::SSP_CR0_POL];
   assign pha      = st_ff.cr0[ssp_pkg::SSP_CR0_PHA];
   assign cmd_m    = !slave && fmt == ssp_pkg::SSP_FMT_CMD;
   assign nbits    = {1'b0, st_ff.cr0[ssp_pkg::SSP_CR0_SIZE_MSB:
                                      ssp_pkg::SSP_CR0_SIZE_LSB]}
                     + 5'h01;
   // the answer after the turnaround has the full word length
   assign limit    = (cmd_m && st_ff.state != ssp_pkg::SSP_RECV)
                     ? ssp_pkg::SSP_CMD_BITS : nbits;
   assign mask     = 16'hffff >> (ssp_pkg::SSP_WORD_BITS - nbits);
   // odd prescale values lose their low bit; zero acts like two
   assign pre_half = (st_ff.cpsr[7:1] == 7'h00) ? 7'h01 : st_ff.cpsr[7:1];
   assign half_len = 16'(pre_half) *
                     (16'(st_ff.cr0[ssp_pkg::SSP_CR0_RATE_MSB:
                                    ssp_pkg::SSP_CR0_RATE_LSB])
                      + 16'h0001);
   // sample level of the incoming clock; polarity only in first format
   assign samp_lvl = (fmt == ssp_pkg::SSP_FMT_SPI) ? !(pol ^ pha)
                   : (fmt != ssp_pkg::SSP_FMT_PULSE);
   assign ev_a     = slave ? (serial_clock_in != st_ff.sclk_q
                              && serial_clock_in == samp_lvl)
                           : (st_ff.tmr == 16'h0000 && !st_ff.phase);
   assign ev_b     = slave ? (serial_clock_in != st_ff.sclk_q
                              && serial_clock_in != samp_lvl && st_ff.phase)
                           : (st_ff.tmr == 16'h0000 && st_ff.phase);
   assign rx_bit   = loop ? st_ff.tx_sh[15] : serial_rx_line;
   assign last     = (st_ff.cnt == limit - 5'h01);
   assign in_frame = st_ff.state == ssp_pkg::SSP_SHIFT
                     || st_ff.state == ssp_pkg::SSP_TURN
                     || st_ff.state == ssp_pkg::SSP_RECV;
   assign start    = (fmt == ssp_pkg::SSP_FMT_PULSE) ? (frame_in && ev_a)
                                                     : !frame_in;

   // bus access phases
   assign acc     = psel && penable;
   assign mapped  = paddr == ssp_pkg::SSP_OFS_CONTROL_ZERO
                    || paddr == ssp_pkg::SSP_OFS_CONTROL_ONE
                    || paddr == ssp_pkg::SSP_OFS_FIFO_DATA
                    || paddr == ssp_pkg::SSP_OFS_FIFO_STATUS
                    || paddr == ssp_pkg::SSP_OFS_CLOCK_PRESCALE
                    || paddr == ssp_pkg::SSP_OFS_INTERRUPT_ID;
   // a data write waits while the send fifo is full rather than drop
   assign pready  = !(acc && pwrite && paddr == ssp_pkg::SSP_OFS_FIFO_DATA
                      && !tx_in_ready);
   assign wr      = acc && pwrite && pready;
   assign rd      = acc && !pwrite;
   assign tx_push = wr && paddr == ssp_pkg::SSP_OFS_FIFO_DATA;
   assign rx_pop  = rd && paddr == ssp_pkg::SSP_OFS_FIFO_DATA;
   assign prdata  = st_ff.rdata;
   assign pslverr = acc && st_ff.err;

   assign ror_set = rx_push && !rx_in_ready
                    && st_ff.cr1[ssp_pkg::SSP_CR1_ROR_IE];
   assign ror_clr = wr && paddr == ssp_pkg::SSP_OFS_CONTROL_ONE
                    && !pwdata[ssp_pkg::SSP_CR1_ROR_IE];
   assign rx_service_irq = st_ff.cr1[ssp_pkg::SSP_CR1_RX_IE]
                           && rx_count >= ssp_pkg::SSP_FIFO_HALF;
   assign tx_service_irq = st_ff.cr1[ssp_pkg::SSP_CR1_TX_IE]
                           && tx_count <= ssp_pkg::SSP_FIFO_HALF;
   assign rx_overrun_irq = st_ff.ror;

   // pin drive
   assign idle_clk          = (fmt == ssp_pkg::SSP_FMT_SPI) && pol;
   assign serial_clock_oe_n = slave || !enable;
   assign frame_oe_n        = slave || !enable;
   assign serial_tx_oe_n    = !enable || (slave && slave_output_disable);
   assign serial_tx_line    = st_ff.state == ssp_pkg::SSP_SHIFT
                              && st_ff.tx_sh[15];
   assign frame_out = (fmt == ssp_pkg::SSP_FMT_PULSE)
                      ? st_ff.state == ssp_pkg::SSP_PULSE
                      : !in_frame;

   always_comb
   begin
      if (!(in_frame || st_ff.state == ssp_pkg::SSP_PULSE))
         serial_clock_out = idle_clk;
      else if (fmt == ssp_pkg::SSP_FMT_SPI)
         serial_clock_out = pol ^ pha ^ st_ff.phase;
      else if (fmt == ssp_pkg::SSP_FMT_PULSE)
         serial_clock_out = !st_ff.phase;
      else
         serial_clock_out = st_ff.phase;
   end

   always_comb
   begin
      nxt_st        = st_ff;
      tx_pop        = 1'b0;
      rx_push       = 1'b0;
      nxt_st.sclk_q = serial_clock_in;
      // master half-period timer runs only around frames
      if (!slave && st_ff.state != ssp_pkg::SSP_IDLE)
         nxt_st.tmr = (st_ff.tmr == 16'h0000) ? half_len - 16'h0001
                                              : st_ff.tmr - 16'h0001;
      unique case (st_ff.state)
         ssp_pkg::SSP_IDLE:
         begin
            nxt_st.phase = 1'b0;
            nxt_st.cnt   = 5'h00;
            nxt_st.tmr   = half_len - 16'h0001;
            if (enable && (slave ? start : tx_valid))
            begin
               // a slave with nothing queued answers with zeros
               tx_pop       = tx_valid;
               // a short frame must not show bits of the word before
               nxt_st.rx_sh = 16'h0000;
               nxt_st.tx_sh = tx_valid ? (cmd_m ? (tx_word << 8)
                              : (tx_word << (ssp_pkg::SSP_WORD_BITS
                                             - nbits))) : 16'h0000;
               nxt_st.state = (!slave && fmt == ssp_pkg::SSP_FMT_PULSE)
                              ? ssp_pkg::SSP_PULSE : ssp_pkg::SSP_SHIFT;
            end
         end
         ssp_pkg::SSP_PULSE, ssp_pkg::SSP_TURN:
         begin
            if (ev_a)
               nxt_st.phase = 1'b1;
            if (ev_b)
            begin
               nxt_st.phase = 1'b0;
               nxt_st.cnt   = 5'h00;
               nxt_st.state = (st_ff.state == ssp_pkg::SSP_PULSE)
                              ? ssp_pkg::SSP_SHIFT : ssp_pkg::SSP_RECV;
            end
         end
         ssp_pkg::SSP_SHIFT, ssp_pkg::SSP_RECV:
         begin
            if (ev_a)
            begin
               nxt_st.phase = 1'b1;
               if (!cmd_m || st_ff.state == ssp_pkg::SSP_RECV)
                  nxt_st.rx_sh = {st_ff.rx_sh[14:0], rx_bit};
               if (slave && last)
               begin
                  rx_push      = 1'b1;
                  nxt_st.state = ssp_pkg::SSP_GAP;
               end
            end
            if (ev_b)
            begin
               nxt_st.phase = 1'b0;
               nxt_st.tx_sh = {st_ff.tx_sh[14:0], 1'b0};
               nxt_st.cnt   = st_ff.cnt + 5'h01;
               if (last && !slave)
               begin
                  rx_push      = !(cmd_m
                                   && st_ff.state == ssp_pkg::SSP_SHIFT);
                  nxt_st.state = rx_push ? ssp_pkg::SSP_GAP
                                         : ssp_pkg::SSP_TURN;
                  nxt_st.cnt   = 5'h00;
               end
            end
            // a slave select released mid-word abandons the word
            if (slave && fmt != ssp_pkg::SSP_FMT_PULSE && frame_in)
               nxt_st.state = ssp_pkg::SSP_IDLE;
         end
         ssp_pkg::SSP_GAP:
         begin
            if (slave)
            begin
               if (fmt == ssp_pkg::SSP_FMT_PULSE || frame_in)
                  nxt_st.state = ssp_pkg::SSP_IDLE;
            end
            else
            begin
               if (ev_a)
                  nxt_st.phase = 1'b1;
               if (ev_b)
                  nxt_st.state = ssp_pkg::SSP_IDLE;
            end
         end
         default:
            nxt_st.state = ssp_pkg::SSP_IDLE;
      endcase
      if (!enable)
         nxt_st.state = ssp_pkg::SSP_IDLE;
      rx_data = nxt_st.rx_sh & mask;

      // overrun: a new event outweighs a clearing write in the same cycle
      nxt_st.ror = ror_set || (st_ff.ror && !ror_clr);

      if (wr)
      begin
         if (paddr == ssp_pkg::SSP_OFS_CONTROL_ZERO)
            nxt_st.cr0 = pwdata[15:0];
         if (paddr == ssp_pkg::SSP_OFS_CONTROL_ONE)
            nxt_st.cr1 = pwdata[6:0];
         if (paddr == ssp_pkg::SSP_OFS_CLOCK_PRESCALE)
            nxt_st.cpsr = pwdata[7:0];
      end

      // read data is captured in the setup phase; unused bits stay zero
      if (psel && !penable)
      begin
         nxt_st.rdata = 32'h0000_0000;
         nxt_st.err   = !mapped;
         unique case (paddr)
            ssp_pkg::SSP_OFS_CONTROL_ZERO:
               nxt_st.rdata[15:0] = st_ff.cr0;
            ssp_pkg::SSP_OFS_CONTROL_ONE:
               nxt_st.rdata[6:0] = st_ff.cr1;
            ssp_pkg::SSP_OFS_FIFO_DATA:
               nxt_st.rdata[15:0] = rx_valid ? rx_word : 16'h0000;
            ssp_pkg::SSP_OFS_FIFO_STATUS:
               nxt_st.rdata[4:0] = {st_ff.state != ssp_pkg::SSP_IDLE
                                    || tx_valid,
                                    !rx_in_ready, rx_valid,
                                    tx_in_ready, !tx_valid};
            ssp_pkg::SSP_OFS_CLOCK_PRESCALE:
               nxt_st.rdata[7:0] = st_ff.cpsr;
            ssp_pkg::SSP_OFS_INTERRUPT_ID:
               nxt_st.rdata[2:0] = {rx_overrun_irq, tx_service_irq,
                                    rx_service_irq};
            default:
               nxt_st.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         st_ff       <= '0;
         st_ff.state <= ssp_pkg::SSP_IDLE;
         st_ff.cr0   <= ssp_pkg::SSP_RST_CONTROL_ZERO;
         st_ff.cr1   <= ssp_pkg::SSP_RST_CONTROL_ONE;
         st_ff.cpsr  <= ssp_pkg::SSP_RST_CLOCK_PRESCALE;
      end
      else
         st_ff <= nxt_st;
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   AST_DISABLED_IDLE: assert property (
      !enable |=> st_ff.state == ssp_pkg::SSP_IDLE)
      else $error("serial transfer while port disabled");
   AST_SOD_QUIET: assert property (
      slave && slave_output_disable |-> serial_tx_oe_n)
      else $error("slave drives transmit line with output disabled");
   AST_ROR_CLEAR: assert property (
      ror_clr && !ror_set |=> !rx_overrun_irq)
      else $error("overrun interrupt survived a clearing write");
   AST_ROR_SET: assert property (
      ror_set |=> rx_overrun_irq)
      else $error("overrun event not recorded");
   AST_RX_IRQ: assert property (
      rx_service_irq |-> st_ff.cr1[ssp_pkg::SSP_CR1_RX_IE]
                         && rx_count >= 4'h4 && rx_valid)
      else $error("receive service interrupt without cause");
   AST_TX_IRQ: assert property (
      st_ff.cr1[ssp_pkg::SSP_CR1_TX_IE] && !tx_valid |-> tx_service_irq)
      else $error("transmit service interrupt missing on empty fifo");
   AST_BUSY: assert property (
      rd && paddr == ssp_pkg::SSP_OFS_FIFO_STATUS && $past(tx_valid)
      && $past(psel && !penable) |-> prdata[4])
      else $error("busy flag clear while send fifo holds data");
   AST_POP: assert property (
      rx_pop && rx_valid && !rx_push |=> rx_count == $past(rx_count) - 4'h1)
      else $error("data read did not pop the receive fifo");
   AST_CLK_IDLE: assert property (
      !slave && st_ff.state == ssp_pkg::SSP_IDLE
      && fmt != ssp_pkg::SSP_FMT_SPI |-> !serial_clock_out)
      else $error("clock polarity applied outside first format");
   AST_LOOP: assert property (
      loop && ev_a && st_ff.state == ssp_pkg::SSP_SHIFT && !cmd_m
      |=> st_ff.rx_sh[0] == $past(st_ff.tx_sh[15]))
      else $error("loopback bit not captured");

   COV_MASTER_WORD: cover property (
      !slave && st_ff.state == ssp_pkg::SSP_SHIFT ##1
      st_ff.state == ssp_pkg::SSP_GAP);
   COV_PULSE_FRAME: cover property (st_ff.state == ssp_pkg::SSP_PULSE);
   COV_CMD_TURN: cover property (st_ff.state == ssp_pkg::SSP_TURN);
   COV_OVERRUN: cover property (ror_set);

endmodule : ssp_port

// *** dv/ssp_peer.sv ***
// Purpose: far-side serial peripheral answering every word with ones
// Assumes: selected while the port's frame output is low
// Notes:   released line toggles so a stale level never passes
module ssp_peer (
   input  wire logic        clock,
   input  wire logic        frame_out,
   input  wire logic        serial_clock_out,
   input  wire logic        serial_tx_line,
   output logic             serial_rx_line,
   output logic      [15:0] seen_word
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tog = 1'b0;
   logic sck_q = 1'b0;
   always @(posedge clock) tog <= ~tog;
   // collects the sent word on rising bit clock edges while selected
   always @(posedge clock)
   begin
      sck_q <= serial_clock_out;
      if (serial_clock_out && !sck_q && !frame_out)
         seen_word <= {seen_word[14:0], serial_tx_line};
   end
   assign serial_rx_line = frame_out ? tog : 1'b1;
endmodule : ssp_peer

// *** dv/tb_top.sv ***
// Purpose: self-checking bench of the serial port
// Assumes: prescale 2, rate 0 keeps frames short
// Notes:   expected words come from a queue model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0, rst = 1'b1, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, v;
   logic        pready, pslverr, er, txoe, rxl, fo, rxi, txi, ori;
   logic        sck, txl;
   logic [15:0] pw;
   int          error_cnt = 0, comparisons = 0, seed = 43525, cyc = 0;
   int          q[$];
   ssp_port DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_clock_in(1'b0),
      .serial_clock_out(sck), .serial_clock_oe_n(), .frame_in(1'b1),
      .frame_out(fo), .frame_oe_n(), .serial_rx_line(rxl),
      .serial_tx_line(txl), .serial_tx_oe_n(txoe), .rx_service_irq(rxi),
      .tx_service_irq(txi), .rx_overrun_irq(ori));
   ssp_peer peer (.clock(clock), .frame_out(fo), .serial_clock_out(sck),
      .serial_tx_line(txl), .serial_rx_line(rxl), .seen_word(pw));
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(negedge clock);
      psel = 1; pwrite = w; paddr = a; pwdata = d;
      @(negedge clock);
      penable = 1;
      n = 0;
      @(posedge clock);
      while (pready !== 1'b1 && n < 99)
      begin
         n++;
         @(posedge clock);
      end
      rd = prdata;
      er = pslverr;
      @(negedge clock);
      psel = 0; penable = 0;
   endtask : bus
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   task automatic idle;
      // busy covers queued words too, so zero means all frames done
      for (int n = 0; n < 300; n++)
      begin
         bus(0, ssp_pkg::SSP_OFS_FIFO_STATUS, 32'h0);
         if (rd[4] === 1'b0) break;
      end
      chk(rd & 32'h10, 32'h0);
   endtask : idle
   task automatic tally_and_finish;
      $display("comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      forever #2 clock = ~clock;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (10) @(negedge clock);
      rst = 0;
      rdchk(ssp_pkg::SSP_OFS_CONTROL_ZERO, 32'h0);
      rdchk(ssp_pkg::SSP_OFS_FIFO_STATUS, 32'h3);
      rdchk(ssp_pkg::SSP_OFS_INTERRUPT_ID, 32'h0);
      v = $random(seed);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ZERO, v);
      rdchk(ssp_pkg::SSP_OFS_CONTROL_ZERO, v & 32'hffff);
      bus(1, ssp_pkg::SSP_OFS_CLOCK_PRESCALE, v);
      rdchk(ssp_pkg::SSP_OFS_CLOCK_PRESCALE, v & 32'hff);
      bus(1, 12'h018, v);
      chk(er, 32'h1);
      rdchk(12'h018, 32'h0);
      $display("test registers done");
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h12);
      chk(txi, 32'h1);
      rdchk(ssp_pkg::SSP_OFS_INTERRUPT_ID, 32'h2);
      // mode select is changed only while the port is off
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h0);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h60);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h70);
      chk(txoe, 32'h1);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h30);
      chk(txoe, 32'h0);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h20);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h0);
      $display("test modes done");
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ZERO, 32'h7);
      bus(1, ssp_pkg::SSP_OFS_CLOCK_PRESCALE, 32'h2);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h1d);
      for (int i = 0; i < 9; i++)
      begin
         v = $random(seed);
         q.push_back(v & 32'hff);
         bus(1, ssp_pkg::SSP_OFS_FIFO_DATA, v);
      end
      idle();
      chk(ori, 32'h1);
      chk(rxi, 32'h1);
      rdchk(ssp_pkg::SSP_OFS_FIFO_STATUS, 32'hf);
      rdchk(ssp_pkg::SSP_OFS_INTERRUPT_ID, 32'h5);
      bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h09);
      chk(ori, 32'h0);
      void'(q.pop_back());
      while (q.size() > 0)
         rdchk(ssp_pkg::SSP_OFS_FIFO_DATA, q.pop_front());
      rdchk(ssp_pkg::SSP_OFS_FIFO_STATUS, 32'h3);
      $display("test loopback done");
      for (int f = 0; f < 3; f++)
      begin
         bus(1, ssp_pkg::SSP_OFS_CONTROL_ZERO, (f << 4) | 32'hf);
         bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h10);
         v = $random(seed);
         bus(1, ssp_pkg::SSP_OFS_FIFO_DATA, v);
         idle();
         rdchk(ssp_pkg::SSP_OFS_FIFO_DATA, 32'hffff);
         if (f == 0)
            chk(pw, v & 32'hffff);
         bus(1, ssp_pkg::SSP_OFS_CONTROL_ONE, 32'h0);
      end
      $display("test formats done");
      tally_and_finish();
   end
endmodule : tb_top
